// ### spi_host_model.sv
`timescale 1ns/1ps
// ****
// Host frame source
// ****
module spi_host_model (
  input wire logic clk_sys,
  output switch_safety_pkg::reg_req_s req,
  output logic cmd_valid
);
  initial begin
    req = '0;
    cmd_valid = 1'b0;
  end
  // Idle bus shows inverted values so stale data never looks valid
  task automatic frame(input logic w, input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    #1;
    req = {w, !w, a, d};
    cmd_valid = 1'b1;
    @(posedge clk_sys);
    #1;
    req = {2'b00, ~a, ~d};
    cmd_valid = 1'b0;
  endtask
endmodule // spi_host_model

// ### spi_watchdog.sv
`timescale 1ns/1ps
`include "switch_safety_config_regs.svh"
module spi_watchdog #(
  parameter logic [31:0] WD0 = 32'(`WD0_CYC),
  parameter logic [31:0] WD1 = 32'(`WD1_CYC),
  parameter logic [31:0] WD2 = 32'(`WD2_CYC),
  parameter logic [31:0] WD3 = 32'(`WD3_CYC)
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic enable,
  input wire logic [1:0] window_sel,
  input wire logic kick,
  output logic expired
);
  logic [31:0] count;
  logic [31:0] limit;

  always_comb begin
    unique case (window_sel)
      2'h0: limit = WD0; // RL11
      2'h1: limit = WD1;
      2'h2: limit = WD2;
      2'h3: limit = WD3;
    endcase
  end

  // Any valid command restarts the window
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      count <= 32'h0;
      expired <= 1'b0;
    end else if (!enable || kick) begin
      count <= 32'h0; // RL10
      expired <= 1'b0;
    end else if (count >= limit - 32'h1) begin
      count <= 32'h0;
      expired <= 1'b1; // RL10
    end else begin
      count <= count + 32'h1;
      expired <= 1'b0;
    end
  end
endmodule // spi_watchdog

// ### switch_safety_config_regs.sv
// Functional notes
// RL1: Two-bit limp selector per channel; code 0 passes the direct input pin.
// RL2: Code 1 freezes output at entry, 2 forces off, 3 forces on.
// RL3: Bit 4 starts converter self-test; result goes to result register.
// RL4: Bit 3 starts current-sense self-test; blocked while current-squared protection runs.
// RL5: Bit 1 starts bandgap self-test; pass or fail recorded in result register.
// RL6: Host writes run bits back to zero after the test completes.
// RL7: Bit 0 enables the converter; reset value disabled.
// RL8: Stagger bit 0 delays second channel first rising edge 100 us.
// RL9: Parallel bit writable only with both channels off and staying off.
// RL10: Watchdog bit enables timeout on absent valid commands.
// RL11: Window codes give 400 us, 400 ms, 800 ms, 1200 ms.
// RL12: Latch-disable 0 latches faults until read; 1 follows faults live.
// RL13: Watchdog expiry sets error flag, held until read and gone.
// RL14: Channel-on bits: bit 1 channel 2, bit 0 channel 1.
// RL15: Reserved bits read zero and ignore writes.
`timescale 1ns/1ps
`include "switch_safety_config_regs.svh"
module switch_safety_config_regs #(
  parameter logic [31:0] WD0 = 32'(`WD0_CYC),
  parameter logic [31:0] WD1 = 32'(`WD1_CYC),
  parameter logic [31:0] WD2 = 32'(`WD2_CYC),
  parameter logic [31:0] WD3 = 32'(`WD3_CYC)
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire switch_safety_pkg::reg_req_s req,
  input wire logic cmd_valid,
  input wire switch_safety_pkg::chan_pair_s chan_on_now,
  input wire switch_safety_pkg::chan_pair_s chan_on_wr,
  input wire logic chan_on_wr_en,
  input wire logic limp_home_mode,
  input wire switch_safety_pkg::chan_pair_s direct_input_pin,
  input wire switch_safety_pkg::chan_pair_s pwm_in,
  input wire logic current_squared_time_protection,
  input wire logic fault_rd,
  input wire logic wd_mask,
  output logic [15:0] rdata,
  output switch_safety_pkg::chan_pair_s chan_out,
  output logic converter_enable,
  output logic converter_selftest_go,
  output logic current_sense_selftest_go,
  output logic bandgap_selftest_go,
  output logic parallel_mode,
  output logic watchdog_error_flag,
  output logic fault_latch_disable
);
  logic [15:0] safety_selftest_control;
  logic [15:0] device_configuration;
  switch_safety_pkg::chan_pair_s entry_state;
  switch_safety_pkg::chan_pair_s next_chan_out;
  switch_safety_pkg::chan_pair_s stagger_pwm;
  logic limp_q;
  logic wd_expired;
  logic stagger_done;
  logic [15:0] stagger_cnt;
  logic [15:0] next_cfg;

  // ************************************************
  // Register writes
  // ************************************************
  always_comb begin
    next_cfg = (req.wdata & `CFG_WR_MASK) | (device_configuration & ~16'(`CFG_WR_MASK)); // RL15
    // Parallel field keeps its value unless both channels stay off
    if (chan_on_now != 2'h0 || (chan_on_wr_en && chan_on_wr != 2'h0)) begin
      next_cfg[`CFG_PARALLEL] = device_configuration[`CFG_PARALLEL]; // RL9 RL14
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      safety_selftest_control <= `SAF_RESET; // RL7
    end else if (req.wr && req.addr == `SAF_OFFSET) begin
      safety_selftest_control <= req.wdata & `SAF_WR_MASK; // RL15 RL6
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      device_configuration <= `CFG_RESET;
    end else if (req.wr && req.addr == `CFG_OFFSET) begin
      device_configuration <= next_cfg;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rdata <= 16'h0000;
    end else if (req.rd) begin
      unique case (req.addr)
        `SAF_OFFSET: rdata <= safety_selftest_control;
        `CFG_OFFSET: rdata <= device_configuration;
        default: rdata <= 16'h0000;
      endcase
    end
  end

  // ************************************************
  // Control outputs
  // ************************************************
  // Converter and current-sense self-tests held off while the protection loop owns the sense path
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      converter_enable <= 1'b0;
      converter_selftest_go <= 1'b0;
      current_sense_selftest_go <= 1'b0;
      bandgap_selftest_go <= 1'b0;
      parallel_mode <= 1'b0;
      fault_latch_disable <= 1'b0;
    end else begin
      converter_enable <= safety_selftest_control[`SAF_CONV_EN]; // RL7
      converter_selftest_go <= safety_selftest_control[`SAF_CONV_RUN] &&
        !current_squared_time_protection; // RL3 RL4
      current_sense_selftest_go <= safety_selftest_control[`SAF_CURRENT_SENSE_RUN] &&
        !current_squared_time_protection; // RL4
      bandgap_selftest_go <= safety_selftest_control[`SAF_BG_RUN]; // RL5
      parallel_mode <= device_configuration[`CFG_PARALLEL];
      fault_latch_disable <= device_configuration[`CFG_LATCH_DIS]; // RL12
    end
  end

  // ************************************************
  // Watchdog and its error flag
  // ************************************************
  spi_watchdog #(
    .WD0(WD0),
    .WD1(WD1),
    .WD2(WD2),
    .WD3(WD3)
  ) u_wd (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .enable(device_configuration[`CFG_WATCHDOG_ENABLE]),
    .window_sel(device_configuration[`CFG_WD_SEL_HI:`CFG_WD_SEL_LO]),
    .kick(cmd_valid),
    .expired(wd_expired)
  );

  // Set wins over a clear-on-read in the same cycle
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      watchdog_error_flag <= 1'b0;
    end else if (wd_expired && !wd_mask) begin
      watchdog_error_flag <= 1'b1; // RL13
    end else if (device_configuration[`CFG_LATCH_DIS]) begin
      watchdog_error_flag <= 1'b0; // RL12
    end else if (fault_rd) begin
      watchdog_error_flag <= 1'b0; // RL13 RL12
    end
  end

  // ************************************************
  // PWM stagger on first rising edge
  // ************************************************
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      stagger_cnt <= 16'h0000;
      stagger_done <= 1'b0;
    end else if (!pwm_in.ch2_output_on) begin
      stagger_cnt <= 16'h0000;
      stagger_done <= stagger_done && pwm_in.ch1_output_on;
    end else if (stagger_cnt < 16'(`STAGGER_CYC)) begin
      stagger_cnt <= stagger_cnt + 16'h0001; // RL8
    end else begin
      stagger_done <= 1'b1;
    end
  end

  always_comb begin
    stagger_pwm.ch1_output_on = pwm_in.ch1_output_on;
    stagger_pwm.ch2_output_on = pwm_in.ch2_output_on && (device_configuration[`CFG_STAGGER_DIS] ||
      stagger_done || stagger_cnt >= 16'(`STAGGER_CYC)); // RL8
  end

  // ************************************************
  // Limp-home output selection
  // ************************************************
  function automatic logic limp_pick(input logic [1:0] sel, input logic direct,
                                     input logic held);
    unique case (sel)
      switch_safety_pkg::LIMP_DIRECT: limp_pick = direct; // RL1
      switch_safety_pkg::LIMP_FREEZE: limp_pick = held; // RL2
      switch_safety_pkg::LIMP_OFF: limp_pick = 1'b0; // RL2
      switch_safety_pkg::LIMP_ON: limp_pick = 1'b1; // RL2
    endcase
  endfunction

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      limp_q <= 1'b0;
      entry_state <= 2'h0;
    end else begin
      limp_q <= limp_home_mode;
      if (limp_home_mode && !limp_q) begin
        entry_state <= chan_out; // RL2
      end
    end
  end

  always_comb begin
    if (limp_home_mode) begin
      next_chan_out.ch2_output_on = limp_pick(
        safety_selftest_control[`SAF_CH2_SEL_HI:`SAF_CH2_SEL_LO],
        direct_input_pin.ch2_output_on, limp_q ? entry_state.ch2_output_on : chan_out.ch2_output_on);
      next_chan_out.ch1_output_on = limp_pick(
        safety_selftest_control[`SAF_CH1_SEL_HI:`SAF_CH1_SEL_LO],
        direct_input_pin.ch1_output_on, limp_q ? entry_state.ch1_output_on : chan_out.ch1_output_on);
    end else begin
      next_chan_out = stagger_pwm & chan_on_now; // RL14
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      chan_out <= 2'h0;
    end else begin
      chan_out <= next_chan_out;
    end
  end
endmodule // switch_safety_config_regs

// ### switch_safety_config_regs.svh
`ifndef SWITCH_SAFETY_CONFIG_REGS_SVH
`define SWITCH_SAFETY_CONFIG_REGS_SVH
`define SAF_OFFSET 4'h8
`define CFG_OFFSET 4'h9
`define SAF_RESET 16'h0000
`define CFG_RESET 16'h0000
`define SAF_WR_MASK 16'h01FB
`define CFG_WR_MASK 16'h005F
`define SAF_CH2_SEL_HI 8
`define SAF_CH2_SEL_LO 7
`define SAF_CH1_SEL_HI 6
`define SAF_CH1_SEL_LO 5
`define SAF_CONV_RUN 4
`define SAF_CURRENT_SENSE_RUN 3
`define SAF_BG_RUN 1
`define SAF_CONV_EN 0
`define CFG_STAGGER_DIS 6
`define CFG_PARALLEL 4
`define CFG_WATCHDOG_ENABLE 3
`define CFG_WD_SEL_HI 2
`define CFG_WD_SEL_LO 1
`define CFG_LATCH_DIS 0
`define CLK_HZ 20000000
`define STAGGER_US 100
`define STAGGER_CYC ((`STAGGER_US * `CLK_HZ) / 1000000)
`define WD0_US 400
`define WD1_MS 400
`define WD2_MS 800
`define WD3_MS 1200
`define WD0_CYC ((64'(`WD0_US) * `CLK_HZ) / 1000000)
`define WD1_CYC ((64'(`WD1_MS) * `CLK_HZ) / 1000)
`define WD2_CYC ((64'(`WD2_MS) * `CLK_HZ) / 1000)
`define WD3_CYC ((64'(`WD3_MS) * `CLK_HZ) / 1000)
`endif

// ### switch_safety_config_regs_bench.sv
`timescale 1ns/1ps
// ****
// Bench
// ****
module switch_safety_config_regs_bench;
  logic clk_sys, rst_b, cmd_valid, chan_on_wr_en, limp_home_mode, fault_rd, wd_mask;
  logic current_squared_time_protection, converter_enable, converter_selftest_go;
  logic current_sense_selftest_go, bandgap_selftest_go, parallel_mode;
  logic watchdog_error_flag, fault_latch_disable;
  logic [15:0] rdata, d;
  switch_safety_pkg::reg_req_s req;
  switch_safety_pkg::chan_pair_s chan_on_now, chan_on_wr, direct_input_pin, pwm_in, chan_out;
  int saf, cfg, err_total, compares, n;
  int hi, run2;
  logic hi_q;
  spi_host_model host_u (.*);
  switch_safety_config_regs #(.WD0(10), .WD1(20), .WD2(30), .WD3(40)) dut_u (.*);
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("errors=%0d compares=%0d", err_total, compares);
    if (err_total == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    logic keep;
    keep = chan_on_now != 2'h0 || (chan_on_wr_en && chan_on_wr != 2'h0);
    host_u.frame(1'b1, a, v);
    if (a == 4'h8) saf = v & 16'h01FB;
    if (a == 4'h9) cfg = (v & 16'h004F) | (keep ? cfg & 16'h0010 : v & 16'h0010);
  endtask
  function automatic logic lh(input int code, input logic pin);
    return code == 0 ? pin : code != 2;
  endfunction
  initial begin
    {rst_b, chan_on_wr_en, limp_home_mode, current_squared_time_protection, fault_rd} = '0;
    {wd_mask, chan_on_now, chan_on_wr, direct_input_pin, pwm_in} = '0;
    void'($urandom(32'hC57F));
    begin : run_all
    cyc(20);
    rst_b = 1'b1;
    cyc(1);
    host_u.frame(1'b0, 4'h8, 16'h0000);
    chk(rdata, 16'h0000);
    // Watchdog kept off here so random traffic cannot trip it
    for (int i = 0; i < 16; i++) begin
      d = 16'($urandom);
      chan_on_now = (i % 4 == 0) ? 2'h0 : 2'($urandom);
      chan_on_wr = 2'($urandom);
      chan_on_wr_en = 1'($urandom);
      if (!i[0]) current_squared_time_protection = 1'($urandom);
      wr(i[0] ? 4'h9 : 4'h8, i[0] ? d & 16'hFFF7 : d);
      cyc(1);
      host_u.frame(1'b0, i[0] ? 4'h9 : 4'h8, 16'h0000);
      chk(rdata, i[0] ? 16'(cfg) : 16'(saf));
      chk(16'({converter_enable, bandgap_selftest_go}), 16'({saf[0], saf[1]}));
      chk(16'({fault_latch_disable, parallel_mode}), 16'({cfg[0], cfg[4]}));
      chk(16'({converter_selftest_go, current_sense_selftest_go}),
          16'({saf[4], saf[3]} & {2{!current_squared_time_protection}}));
    end
    {chan_on_wr_en, current_squared_time_protection} = '0;
    wr(4'h8, 16'h0000);
    host_u.frame(1'b0, 4'h3, 16'h0000);
    chk(rdata, 16'h0000);
    chan_on_now = 2'h3;
    wr(4'h9, 16'h0000);
    cyc(2);
    pwm_in = 2'h3;
    cyc(5);
    chk(16'(chan_out), 16'h0001);
    cyc(1995);
    chk(16'(chan_out), 16'h0001);
    cyc(1);
    chk(16'(chan_out), 16'h0003);
    wr(4'h9, 16'h0040);
    direct_input_pin = 2'h1;
    for (int c = 0; c < 4; c++) begin
      wr(4'h8, 16'((c << 7) | ((3 - c) << 5)));
      cyc(3);
      limp_home_mode = 1'b1;
      cyc(1);
      pwm_in = 2'h0;
      cyc(3);
      chk(16'(chan_out), 16'({lh(c, 1'b0), lh(3 - c, 1'b1)}));
      limp_home_mode = 1'b0;
      pwm_in = 2'h3;
      cyc(3);
      chk(16'(chan_out), 16'h0003);
    end
    for (int c = 0; c < 4; c++) begin
      wr(4'h9, 16'(8 | (c << 1)));
      n = 0;
      while (watchdog_error_flag !== 1'b1 && n < 300) begin
        cyc(1);
        n++;
      end
      if (n == 300) begin
        err_total++;
        disable run_all;
      end
      chk(16'(n >= 10 * c + 9 && n <= 10 * c + 13), 16'h0001);
      cyc(5);
      chk(16'(watchdog_error_flag), 16'h0001);
      wr(4'h9, 16'h0000);
      fault_rd = 1'b1;
      cyc(1);
      fault_rd = 1'b0;
      cyc(2);
      chk(16'(watchdog_error_flag), 16'h0000);
    end
    // Masked expiry stays silent; mask held over the write so no stale pulse lands
    wd_mask = 1'b1;
    wr(4'h9, 16'h0008);
    cyc(30);
    chk(16'(watchdog_error_flag), 16'h0000);
    wr(4'h9, 16'h0009);
    wd_mask = 1'b0;
    hi = 0;
    run2 = 0;
    hi_q = 1'b0;
    for (int k = 0; k < 35; k++) begin
      cyc(1);
      run2 += int'(watchdog_error_flag && hi_q);
      hi += int'(watchdog_error_flag);
      hi_q = watchdog_error_flag;
    end
    chk(16'(hi > 0 && run2 == 0), 16'h0001);
    wr(4'h9, 16'h0000);
    wr(4'h8, 16'h0001);
    cyc(3);
    chk(16'(converter_enable), 16'h0001);
    // Mid-run reset must return the self-test control register and converter enable to their reset values
    rst_b = 1'b0;
    cyc(2);
    rst_b = 1'b1;
    saf = 0;
    cfg = 0;
    cyc(1);
    chk(16'(converter_enable), 16'h0000);
    host_u.frame(1'b0, 4'h8, 16'h0000);
    chk(rdata, 16'(saf));
    cyc(60);
    chk(16'(watchdog_error_flag), 16'h0000);
    end
    end_sim();
  end
endmodule // switch_safety_config_regs_bench

// ### switch_safety_config_regs_checker.sv
`timescale 1ns/1ps
// ****
// Port checks
// ****
module switch_safety_config_regs_checker (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire switch_safety_pkg::reg_req_s req,
  input wire logic cmd_valid,
  input wire switch_safety_pkg::chan_pair_s chan_on_now,
  input wire logic current_squared_time_protection,
  input wire logic fault_rd,
  input wire logic [15:0] rdata,
  input wire logic converter_enable,
  input wire logic converter_selftest_go,
  input wire logic current_sense_selftest_go,
  input wire logic bandgap_selftest_go,
  input wire logic parallel_mode,
  input wire logic watchdog_error_flag,
  input wire logic fault_latch_disable
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  property p_rsv;
    req.rd |=> (rdata & ($past(req.addr) == 4'h9 ? 16'hFFA0 : 16'hFE04)) == 16'h0000;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits nonzero");
  property p_cv;
    req.wr && req.addr == 4'h8 |-> ##2 converter_enable == $past(req.wdata[0], 2);
  endproperty
  a_cv: assert property (p_cv) else $error("converter enable wrong");
  property p_bg;
    req.wr && req.addr == 4'h8 |-> ##2 bandgap_selftest_go == $past(req.wdata[1], 2);
  endproperty
  a_bg: assert property (p_bg) else $error("bandgap run wrong");
  property p_fl;
    req.wr && req.addr == 4'h9 |-> ##2 fault_latch_disable == $past(req.wdata[0], 2);
  endproperty
  a_fl: assert property (p_fl) else $error("latch disable wrong");
  property p_i2t;
    current_squared_time_protection [*3] |-> !converter_selftest_go && !current_sense_selftest_go;
  endproperty
  a_i2t: assert property (p_i2t) else $error("self-test under protection");
  property p_par;
    req.wr && req.addr == 4'h9 && chan_on_now != 2'h0 |-> ##2 $stable(parallel_mode);
  endproperty
  a_par: assert property (p_par) else $error("parallel bit taken");
  property p_wd;
    cmd_valid |-> ##2 (!$rose(watchdog_error_flag)) [*3];
  endproperty
  a_wd: assert property (p_wd) else $error("watchdog tripped after command");
  property p_hold;
    watchdog_error_flag && !fault_rd |=> watchdog_error_flag || fault_latch_disable;
  endproperty
  a_hold: assert property (p_hold) else $error("error flag dropped unread");
  c_wr: cover property (req.wr && req.addr == 4'h9);
  c_wd: cover property ($rose(watchdog_error_flag));
  c_par: cover property ($rose(parallel_mode));
endmodule // switch_safety_config_regs_checker
bind switch_safety_config_regs switch_safety_config_regs_checker chk_u (.*);

// ### switch_safety_pkg.sv
package switch_safety_pkg;
  typedef enum logic [1:0] {
    LIMP_DIRECT = 2'h0,
    LIMP_FREEZE = 2'h1,
    LIMP_OFF = 2'h2,
    LIMP_ON = 2'h3
  } limp_sel_e;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] addr;
    logic [15:0] wdata;
  } reg_req_s;
  typedef struct packed {
    logic ch2_output_on;
    logic ch1_output_on;
  } chan_pair_s;
endpackage
